// *** rtl/scx_pkg.sv ***
// package for the system-control exception check block
// assumes one core clock and a synchronous active-high reset
package scx_pkg;

  // ---------------------------------------------------------------
  // extension control bit positions
  // ---------------------------------------------------------------
  localparam int LARGE_PAGE_BIT = 4;
  localparam int PHYS_EXT_BIT = 5;
  localparam int GLOBAL_PAGE_BIT = 7;
  localparam int DEBUG_EXT_BIT = 3;
  localparam int HW_TRAP_BIT = 6;
  localparam logic [31:0] EXT_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] EXT_CTRL_WMASK = 32'h000007FF;

  // ---------------------------------------------------------------
  // breakpoint registers
  // ---------------------------------------------------------------
  localparam logic [31:0] BP_STAT_RESET = 32'hFFFF0FF0;
  localparam int BP_STAT_RSVD_BIT = 12;
  localparam logic [31:0] BP_CTRL_RESET = 32'h00000400;
  localparam logic [31:0] BP_CTRL_ZERO = 32'h0000D800;
  localparam int BP_KIND_LSB = 16;
  localparam int BP_KIND_STEP = 4;
  localparam int BP_SLOTS = 4;

  // ---------------------------------------------------------------
  // breakpoint kinds and access kinds
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCX_BK_EXEC = 2'h0,
    SCX_BK_WRITE = 2'h1,
    SCX_BK_PORT = 2'h2,
    SCX_BK_DATA = 2'h3
  } scx_bkind_t;

  typedef enum logic [1:0] {
    SCX_AC_FETCH = 2'h0,
    SCX_AC_READ = 2'h1,
    SCX_AC_WRITE = 2'h2,
    SCX_AC_PORT = 2'h3
  } scx_acc_t;

  // register selectors for privileged moves
  typedef enum logic [3:0] {
    SCX_RS_EXT = 4'h0,
    SCX_RS_STAT = 4'h1,
    SCX_RS_CTRL = 4'h2,
    SCX_RS_SLOT_A = 4'h3,
    SCX_RS_SLOT_B = 4'h4,
    SCX_RS_TEST = 4'h5
  } scx_rsel_t;

  // ---------------------------------------------------------------
  // exception vectors
  // ---------------------------------------------------------------
  localparam logic [7:0] VEC_DIVIDE = 8'h00;
  localparam logic [7:0] VEC_OPCODE = 8'h06;
  localparam logic [7:0] VEC_PROTECT = 8'h0D;
  localparam logic [7:0] VEC_PAGE = 8'h0E;
  localparam logic [7:0] VEC_ALIGN = 8'h11;
  localparam logic [7:0] VEC_MCHECK = 8'h12;
  localparam logic [7:0] VEC_VFLOAT = 8'h13;

  localparam logic [7:0] AR_INVALID_A = 8'h80;
  localparam logic [7:0] AR_INVALID_B = 8'h00;
  localparam logic [3:0] MAX_INSN_LEN = 4'hF;
  localparam int MODE_BITS = 3;
  localparam int DESC_ACCESSED_BIT = 0;
  localparam int PHYS_LO_BITS = 32;

  // register move request
  typedef struct packed {
    logic valid;
    logic write;
    scx_rsel_t sel;
    logic [31:0] data;
  } scx_move_t;

  // core condition reports: single-cycle strobes plus the insn_len, vf_flags and align_on values
  typedef struct packed {
    logic divide_err;
    logic lock_misuse;
    logic [4:0] insn_len;
    logic pte_rsvd;
    logic unaligned;
    logic align_on;
    logic vf_err;
    logic [5:0] vf_flags;
    logic hw_err;
  } scx_cond_t;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic fault_ptr;
  } scx_trap_t;

endpackage : scx_pkg

// *** rtl/scx_checks.sv ***
// system-control checks: extension control, breakpoint registers,
// legacy debug slot aliasing and exception vector selection
// assumes the core presents moves and condition strobes synchronously
// How it works
// RQ1: physical extension plus paging drives four extra address lines, 36-bit.
// RQ2: global enable keeps global entries on task switch or base write; here base_write is task_switch alone, no base register write is decoded.
// RQ3: large page enable gives 4K/4M pages, or 4K/2M with extension.
// RQ4: extension, global and large page features act in protected mode only.
// RQ5: access-rights bytes 80H and 00H mark invalid descriptors.
// RQ6: accessed-bit locked update happens only when bit is clear.
// RQ7: status register bit 12 can never be written to one.
// RQ8: kind 00 breaks on execution, 01 on data writes only.
// RQ9: port kind breaks on port access when debug extension set.
// RQ10: remaining kind breaks on data reads or writes, never fetches.
// RQ11: control register bits 11, 12, 14, 15 always read zero.
// RQ12: debug extension clear aliases legacy slots to status and control.
// RQ13: debug extension set makes legacy slot access invalid opcode.
// RQ14: test register moves raise invalid opcode.
// RQ15: vector float faults recorded in control/status, vector 19.
// RQ16: machine check vector 18 only when trap enable set, clear at reset.
// RQ17: writing one to a reserved extension control bit gives vector 13.
// RQ18: reserved bit set in translation entry gives page fault, vector 14.
// RQ19: unaligned reference with checking active gives vector 17.
// RQ20: divide error vector 0 saves pointer at the faulting divide.
// RQ21: most negative signed quotient raises no divide error.
// RQ22: lock prefix misuse gives invalid opcode, vector 6.
// RQ23: instructions longer than 15 bytes give vector 13.
// RQ24: kind 10 selects port breaks, kind 11 data read-or-write.
`timescale 1ns/1ns

module scx_checks #(
  parameter int ADDR_HI = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // processor mode
  input wire logic protected_mode,
  input wire logic paging_on,
  // register moves
  input wire scx_pkg::scx_move_t move,
  output logic [31:0] rd_data,
  // translation and descriptor events
  input wire logic task_switch,
  input wire logic [35:0] lin_phys_addr,
  input wire logic desc_load,
  input wire logic [7:0] desc_access,
  // breakpoint probe
  input wire logic [31:0] probe_hit,
  input wire scx_pkg::scx_acc_t probe_kind,
  input wire logic probe_valid,
  // core conditions
  input wire scx_pkg::scx_cond_t cond,
  // results
  output logic [35:0] phys_addr,
  output logic tlb_flush_all,
  output logic tlb_flush_nonglobal,
  output logic large_4m_ok,
  output logic large_2m_ok,
  output logic desc_invalid,
  output logic desc_locked_rmw,
  output logic [scx_pkg::BP_SLOTS-1:0] bp_hit,
  output logic [5:0] vf_status,
  output scx_pkg::scx_trap_t trap
);

  localparam int BP_SLOTS_L = scx_pkg::BP_SLOTS;
  // ADDR_HI has to match the upper part of the 36-bit address ports
  localparam int PA_LO = scx_pkg::PHYS_LO_BITS;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic scx_pkg::scx_bkind_t kind_of(input logic [31:0] c,
                                                  input int i);
    kind_of = scx_pkg::scx_bkind_t'(c[scx_pkg::BP_KIND_LSB +
                                      i * scx_pkg::BP_KIND_STEP +: 2]);
  endfunction : kind_of

  function automatic logic kind_match(input scx_pkg::scx_bkind_t k,
                                      input scx_pkg::scx_acc_t a,
                                      input logic dbg);
    case (k)
      scx_pkg::SCX_BK_EXEC: kind_match = (a == scx_pkg::SCX_AC_FETCH);
      scx_pkg::SCX_BK_WRITE: kind_match = (a == scx_pkg::SCX_AC_WRITE);
      // port kind with debug extension clear is undefined: no break
      scx_pkg::SCX_BK_PORT: kind_match = dbg && (a == scx_pkg::SCX_AC_PORT);
      scx_pkg::SCX_BK_DATA: kind_match = (a == scx_pkg::SCX_AC_READ) ||
                                         (a == scx_pkg::SCX_AC_WRITE);
      default: kind_match = 1'b0;
    endcase
  endfunction : kind_match

  // ---------------------------------------------------------------
  // registers and decode
  // ---------------------------------------------------------------
  logic [31:0] ext_reg;
  logic [31:0] stat_reg;
  logic [31:0] ctrl_reg;
  logic [5:0] vf_reg;
  logic dbg_ext;
  logic pm_phys;
  logic pm_glob;
  logic pm_large;
  logic slot_ref;
  logic slot_trap;
  logic to_stat;
  logic to_ctrl;
  logic ext_rsvd_err;
  logic len_err;
  logic [BP_SLOTS_L-1:0] bp_next;

  assign dbg_ext = ext_reg[scx_pkg::DEBUG_EXT_BIT];
  // RQ4 protected mode gate
  assign pm_phys = protected_mode && ext_reg[scx_pkg::PHYS_EXT_BIT];
  assign pm_glob = protected_mode && ext_reg[scx_pkg::GLOBAL_PAGE_BIT];
  assign pm_large = protected_mode && ext_reg[scx_pkg::LARGE_PAGE_BIT];
  assign slot_ref = move.valid && (move.sel == scx_pkg::SCX_RS_SLOT_A ||
                                   move.sel == scx_pkg::SCX_RS_SLOT_B);
  // RQ13 slot trap
  assign slot_trap = slot_ref && dbg_ext;
  // RQ12 legacy aliasing
  assign to_stat = move.valid && (move.sel == scx_pkg::SCX_RS_STAT ||
                   (move.sel == scx_pkg::SCX_RS_SLOT_A && !dbg_ext));
  assign to_ctrl = move.valid && (move.sel == scx_pkg::SCX_RS_CTRL ||
                   (move.sel == scx_pkg::SCX_RS_SLOT_B && !dbg_ext));
  // RQ17 reserved write check
  assign ext_rsvd_err = move.valid && move.write &&
                        move.sel == scx_pkg::SCX_RS_EXT &&
                        |(move.data & ~scx_pkg::EXT_CTRL_WMASK);
  // RQ23 length limit
  assign len_err = cond.insn_len > {1'b0, scx_pkg::MAX_INSN_LEN};

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
      ext_reg <= scx_pkg::EXT_CTRL_RESET;
    else if (move.write && move.sel == scx_pkg::SCX_RS_EXT &&
             move.valid && !ext_rsvd_err)
      ext_reg <= move.data;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      stat_reg <= scx_pkg::BP_STAT_RESET;
    else if (to_stat && move.write)
    begin
      stat_reg <= move.data;
      // RQ7 bit 12 locked
      stat_reg[scx_pkg::BP_STAT_RSVD_BIT] <= 1'b0;
      // a hit in the same cycle as the write is not lost
      if (probe_valid)
        stat_reg[BP_SLOTS_L-1:0] <= move.data[BP_SLOTS_L-1:0] | bp_next;
    end
    else if (probe_valid)
      stat_reg[BP_SLOTS_L-1:0] <= stat_reg[BP_SLOTS_L-1:0] | bp_next;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      ctrl_reg <= scx_pkg::BP_CTRL_RESET;
    else if (to_ctrl && move.write)
      // RQ11 hardwired zeros
      ctrl_reg <= move.data & ~scx_pkg::BP_CTRL_ZERO;
  end

  // RQ15 sticky vector float status
  always_ff @(posedge mclk)
  begin
    if (srst)
      vf_reg <= '0;
    else if (cond.vf_err)
      vf_reg <= vf_reg | cond.vf_flags;
  end
  assign vf_status = vf_reg;

  always_ff @(posedge mclk)
  begin
    if (srst)
      rd_data <= '0;
    else if (move.valid && !move.write)
    begin
      if (to_stat)
        rd_data <= stat_reg;
      else if (to_ctrl)
        rd_data <= ctrl_reg;
      else if (move.sel == scx_pkg::SCX_RS_EXT)
        rd_data <= ext_reg;
      else
        rd_data <= '0;
    end
  end

  // ---------------------------------------------------------------
  // breakpoint matching
  // ---------------------------------------------------------------
  always_comb
  begin
    bp_next = '0;
    // RQ8 RQ9 RQ10 RQ24 kind decode
    for (int i = 0; i < BP_SLOTS_L; i++)
      bp_next[i] = probe_hit[i] &&
                   kind_match(kind_of(ctrl_reg, i), probe_kind, dbg_ext);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      bp_hit <= '0;
    else
      bp_hit <= probe_valid ? bp_next : '0;
  end

  // ---------------------------------------------------------------
  // translation effects
  // ---------------------------------------------------------------
  logic base_write;
  assign base_write = task_switch;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      phys_addr <= '0;
      large_4m_ok <= 1'b0;
      large_2m_ok <= 1'b0;
    end
    else
    begin
      // RQ1 extra address lines
      phys_addr[PA_LO-1:0] <= lin_phys_addr[PA_LO-1:0];
      phys_addr[PA_LO +: ADDR_HI] <= (pm_phys && paging_on) ?
                                     lin_phys_addr[PA_LO +: ADDR_HI] : '0;
      // RQ3 page sizes
      large_4m_ok <= pm_large && !pm_phys;
      large_2m_ok <= pm_large && pm_phys;
    end
  end

  // RQ2 global entries kept
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      tlb_flush_all <= 1'b0;
      tlb_flush_nonglobal <= 1'b0;
    end
    else
    begin
      tlb_flush_all <= base_write && !pm_glob;
      tlb_flush_nonglobal <= base_write && pm_glob;
    end
  end

  // RQ5 RQ6 descriptor checks
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      desc_invalid <= 1'b0;
      desc_locked_rmw <= 1'b0;
    end
    else
    begin
      desc_invalid <= desc_load && (desc_access == scx_pkg::AR_INVALID_A ||
                                    desc_access == scx_pkg::AR_INVALID_B);
      desc_locked_rmw <= desc_load &&
                         !desc_access[scx_pkg::DESC_ACCESSED_BIT];
    end
  end

  // ---------------------------------------------------------------
  // exception selection, highest priority first
  // ---------------------------------------------------------------
  scx_pkg::scx_trap_t trap_next;
  always_comb
  begin
    trap_next = '0;
    trap_next.valid = 1'b1;
    // RQ22 RQ14 RQ13 invalid opcode sources
    if (cond.lock_misuse || slot_trap ||
        (move.valid && move.sel == scx_pkg::SCX_RS_TEST))
      trap_next.vector = scx_pkg::VEC_OPCODE;
    // RQ17 RQ23 protection
    else if (ext_rsvd_err || len_err)
      trap_next.vector = scx_pkg::VEC_PROTECT;
    // RQ18 page fault
    else if (cond.pte_rsvd)
      trap_next.vector = scx_pkg::VEC_PAGE;
    // RQ19 alignment
    else if (cond.unaligned && cond.align_on)
      trap_next.vector = scx_pkg::VEC_ALIGN;
    // RQ20 RQ21 divide error points at divide; core filters min quotient
    else if (cond.divide_err)
    begin
      trap_next.vector = scx_pkg::VEC_DIVIDE;
      trap_next.fault_ptr = 1'b1;
    end
    // RQ16 gated machine check
    else if (cond.hw_err && ext_reg[scx_pkg::HW_TRAP_BIT])
      trap_next.vector = scx_pkg::VEC_MCHECK;
    // RQ15 vector float
    else if (cond.vf_err)
      trap_next.vector = scx_pkg::VEC_VFLOAT;
    else
      trap_next.valid = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      trap <= '0;
    else
      trap <= trap_next;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_stat_bit_zero: assert property ( // RQ7
    @(posedge mclk) disable iff (srst)
    $past(to_stat && move.write) |-> !stat_reg[scx_pkg::BP_STAT_RSVD_BIT])
    else $error("status bit 12 set by write");
  a_ctrl_rsvd_zero: assert property ( // RQ11
    @(posedge mclk) disable iff (srst)
    (ctrl_reg & scx_pkg::BP_CTRL_ZERO) == '0)
    else $error("control reserved bits not zero");
  a_slot_trap_ud: assert property ( // RQ13
    @(posedge mclk) disable iff (srst)
    slot_trap |=> trap.valid && trap.vector == scx_pkg::VEC_OPCODE)
    else $error("slot reference did not trap");
  a_test_reg_ud: assert property ( // RQ14
    @(posedge mclk) disable iff (srst)
    move.valid && move.sel == scx_pkg::SCX_RS_TEST
    |=> trap.valid && trap.vector == scx_pkg::VEC_OPCODE)
    else $error("test register move did not trap");
  a_mcheck_gated: assert property ( // RQ16
    @(posedge mclk) disable iff (srst)
    trap.valid && trap.vector == scx_pkg::VEC_MCHECK
    |-> $past(ext_reg[scx_pkg::HW_TRAP_BIT]))
    else $error("machine check while disabled");
  a_len_limit: assert property ( // RQ23
    @(posedge mclk) disable iff (srst)
    cond.insn_len > 5'(scx_pkg::MAX_INSN_LEN) && !cond.lock_misuse &&
    !slot_ref && !(move.valid && move.sel == scx_pkg::SCX_RS_TEST)
    |=> trap.vector == scx_pkg::VEC_PROTECT)
    else $error("long instruction not protected");
  a_high_addr: assert property ( // RQ1
    @(posedge mclk) disable iff (srst)
    !(pm_phys && paging_on) |=> phys_addr[PA_LO +: ADDR_HI] == '0)
    else $error("upper address lines driven");
  a_mode_gate: assert property ( // RQ4
    @(posedge mclk) disable iff (srst)
    !protected_mode |=> !large_4m_ok && !large_2m_ok)
    else $error("large pages outside protected mode");
  a_page_sizes: assert property ( // RQ3
    @(posedge mclk) disable iff (srst)
    pm_large && !pm_phys |=> large_4m_ok && !large_2m_ok)
    else $error("wrong large page size offered");
  a_fetch_no_data: assert property ( // RQ10
    @(posedge mclk) disable iff (srst)
    probe_valid && probe_kind == scx_pkg::SCX_AC_FETCH &&
    kind_of(ctrl_reg, 0) == scx_pkg::SCX_BK_DATA |=> !bp_hit[0])
    else $error("data kind broke on fetch");
  a_global_keep: assert property ( // RQ2
    @(posedge mclk) disable iff (srst)
    task_switch && pm_glob |=> tlb_flush_nonglobal && !tlb_flush_all)
    else $error("global entries flushed");
  a_desc_inval: assert property ( // RQ5
    @(posedge mclk) disable iff (srst)
    desc_load && desc_access == scx_pkg::AR_INVALID_A |=> desc_invalid)
    else $error("80H descriptor accepted");
  a_accessed_rmw: assert property ( // RQ6
    @(posedge mclk) disable iff (srst)
    desc_load && desc_access[scx_pkg::DESC_ACCESSED_BIT]
    |=> !desc_locked_rmw)
    else $error("locked update with accessed bit set");
  a_divide_ptr: assert property ( // RQ20
    @(posedge mclk) disable iff (srst)
    trap.valid && trap.vector == scx_pkg::VEC_DIVIDE |-> trap.fault_ptr)
    else $error("divide error pointer not at divide");
  a_vf_sticky: assert property ( // RQ15
    @(posedge mclk) disable iff (srst)
    cond.vf_err
    |=> (vf_status & $past(cond.vf_flags)) == $past(cond.vf_flags))
    else $error("vector float flags not recorded");

endmodule : scx_checks

// *** bench/system_control_exception_checks_tb_top.sv ***
// self-checking bench for the system-control exception check block
// assumes scx_pkg and scx_checks are compiled first; no far-side model
`timescale 1ns/1ns

module system_control_exception_checks_tb_top;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic srst;
  logic protected_mode;
  logic paging_on;
  scx_pkg::scx_move_t move;
  logic [31:0] rd_data;
  logic task_switch;
  logic [35:0] lin_phys_addr;
  logic desc_load;
  logic [7:0] desc_access;
  logic [31:0] probe_hit;
  scx_pkg::scx_acc_t probe_kind;
  logic probe_valid;
  scx_pkg::scx_cond_t cond;
  logic [35:0] phys_addr;
  logic tlb_flush_all;
  logic tlb_flush_nonglobal;
  logic large_4m_ok;
  logic large_2m_ok;
  logic desc_invalid;
  logic desc_locked_rmw;
  logic [3:0] bp_hit;
  logic [5:0] vf_status;
  scx_pkg::scx_trap_t trap;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam int CYC_MAX = 3000;
  scx_pkg::scx_acc_t pk_t [4] = '{scx_pkg::SCX_AC_FETCH,
    scx_pkg::SCX_AC_READ, scx_pkg::SCX_AC_WRITE, scx_pkg::SCX_AC_PORT};
  logic [3:0] bx_t [4] = '{4'h1, 4'h8, 4'hA, 4'h0};
  scx_pkg::scx_cond_t cv;

  always #4 mclk = ~mclk;

  scx_checks i_dut (
    .mclk(mclk), .srst(srst),
    .protected_mode(protected_mode), .paging_on(paging_on),
    .move(move), .rd_data(rd_data),
    .task_switch(task_switch), .lin_phys_addr(lin_phys_addr),
    .desc_load(desc_load), .desc_access(desc_access),
    .probe_hit(probe_hit), .probe_kind(probe_kind),
    .probe_valid(probe_valid), .cond(cond),
    .phys_addr(phys_addr), .tlb_flush_all(tlb_flush_all),
    .tlb_flush_nonglobal(tlb_flush_nonglobal),
    .large_4m_ok(large_4m_ok), .large_2m_ok(large_2m_ok),
    .desc_invalid(desc_invalid), .desc_locked_rmw(desc_locked_rmw),
    .bp_hit(bp_hit), .vf_status(vf_status), .trap(trap)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // a quiet cycle only checks that no trap is raised
  task automatic chk_trap(input logic v, input logic [7:0] vec);
    chk({27'h0, trap.valid, v ? trap.vector : 8'h00}, {27'h0, v, vec});
  endtask : chk_trap

  // one request cycle; outputs are looked at 1 ns after the edge that takes it
  task automatic step(input scx_pkg::scx_move_t m = '0,
    input scx_pkg::scx_cond_t c = '0, input logic [2:0] aux = 3'h0,
    input logic [7:0] da = 8'h00,
    input scx_pkg::scx_acc_t pk = scx_pkg::SCX_AC_FETCH);
    @(posedge mclk);
    move <= m;
    cond <= c;
    {task_switch, desc_load, probe_valid} <= aux;
    desc_access <= da;
    probe_kind <= pk;
    @(posedge mclk);
    move <= '0;
    cond <= '0;
    {task_switch, desc_load, probe_valid} <= 3'h0;
    #1;
  endtask : step

  task automatic wr(input scx_pkg::scx_rsel_t s, input logic [31:0] d);
    step(.m({2'b11, s, d}));
  endtask : wr

  task automatic rd(input scx_pkg::scx_rsel_t s);
    step(.m({2'b10, s, 32'h00000000}));
  endtask : rd

  // ---------------------------------------------------------------
  // hang guard
  // ---------------------------------------------------------------
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX)
    begin
      err_total++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    srst <= 1'b1;
    protected_mode <= 1'b0;
    paging_on <= 1'b0;
    move <= '0;
    task_switch <= 1'b0;
    lin_phys_addr <= 36'h000000000;
    desc_load <= 1'b0;
    desc_access <= 8'h00;
    probe_hit <= 32'h0000000F;
    probe_kind <= scx_pkg::SCX_AC_FETCH;
    probe_valid <= 1'b0;
    cond <= '0;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    // reset values and the inhibited machine check
    rd(scx_pkg::SCX_RS_EXT);
    chk(36'(rd_data), 36'h000000000);
    rd(scx_pkg::SCX_RS_STAT);
    chk(36'(rd_data), 36'h0FFFF0FF0);
    rd(scx_pkg::SCX_RS_CTRL);
    chk(36'(rd_data), 36'h000000400);
    cv = '0;
    cv.hw_err = 1'b1;
    step(.c(cv));
    chk_trap(1'b0, 8'h00);
    $display("test reset values done");
    // reserved bits, refused writes and test register moves
    wr(scx_pkg::SCX_RS_STAT, 32'hFFFFFFFF);
    rd(scx_pkg::SCX_RS_STAT);
    chk(36'(rd_data[12]), 36'h0);
    wr(scx_pkg::SCX_RS_CTRL, 32'hFFFFFFFF);
    rd(scx_pkg::SCX_RS_CTRL);
    chk(36'(rd_data & 32'h0000D800), 36'h0);
    wr(scx_pkg::SCX_RS_EXT, 32'h00000800);
    chk_trap(1'b1, scx_pkg::VEC_PROTECT);
    rd(scx_pkg::SCX_RS_EXT);
    chk(36'(rd_data), 36'h0);
    wr(scx_pkg::SCX_RS_TEST, 32'h00000000);
    chk_trap(1'b1, scx_pkg::VEC_OPCODE);
    $display("test reserved bits done");
    // legacy slots alias while the debug extension is clear
    wr(scx_pkg::SCX_RS_SLOT_B, 32'h321000FF);
    chk_trap(1'b0, 8'h00);
    rd(scx_pkg::SCX_RS_CTRL);
    chk(36'(rd_data | 32'h00000400), 36'h0321004FF);
    wr(scx_pkg::SCX_RS_SLOT_A, 32'h00000000);
    rd(scx_pkg::SCX_RS_STAT);
    chk(36'(rd_data[3:0]), 36'h0);
    rd(scx_pkg::SCX_RS_SLOT_B);
    chk(36'(rd_data | 32'h00000400), 36'h0321004FF);
    // slot kinds: exec, write, port, data
    for (int i = 0; i < 4; i++)
    begin
      step(.aux(3'h1), .pk(pk_t[i]));
      chk(36'(bp_hit), 36'(bx_t[i]));
    end
    // only slots whose address matched may break
    probe_hit <= 32'h00000002;
    step(.aux(3'h1), .pk(scx_pkg::SCX_AC_WRITE));
    chk(36'(bp_hit), 36'h2);
    probe_hit <= 32'h0000000F;
    wr(scx_pkg::SCX_RS_EXT, 32'h00000008);
    step(.aux(3'h1), .pk(scx_pkg::SCX_AC_PORT));
    chk(36'(bp_hit), 36'h4);
    rd(scx_pkg::SCX_RS_STAT);
    chk(36'(rd_data[3:0]), 36'hF);
    rd(scx_pkg::SCX_RS_SLOT_A);
    chk_trap(1'b1, scx_pkg::VEC_OPCODE);
    wr(scx_pkg::SCX_RS_SLOT_B, 32'h00000000);
    chk_trap(1'b1, scx_pkg::VEC_OPCODE);
    // a hit in the cycle of a status write is kept
    step(.m({2'b11, scx_pkg::SCX_RS_STAT, 32'h00000000}), .aux(3'h1));
    rd(scx_pkg::SCX_RS_STAT);
    chk(36'(rd_data[3:0]), 36'h1);
    $display("test breakpoints done");
    // memory management flags
    wr(scx_pkg::SCX_RS_EXT, 32'h00000020);
    @(posedge mclk);
    protected_mode <= 1'b1;
    paging_on <= 1'b1;
    lin_phys_addr <= 36'hA12345678;
    step();
    chk(phys_addr, 36'hA12345678);
    protected_mode <= 1'b0;
    step();
    chk(phys_addr, 36'h012345678);
    protected_mode <= 1'b1;
    paging_on <= 1'b0;
    step();
    chk(phys_addr, 36'h012345678);
    paging_on <= 1'b1;
    wr(scx_pkg::SCX_RS_EXT, 32'h00000010);
    step();
    chk(36'({large_4m_ok, large_2m_ok}), 36'h2);
    wr(scx_pkg::SCX_RS_EXT, 32'h00000030);
    step();
    chk(36'({large_4m_ok, large_2m_ok}), 36'h1);
    protected_mode <= 1'b0;
    step();
    chk(36'({large_4m_ok, large_2m_ok}), 36'h0);
    protected_mode <= 1'b1;
    wr(scx_pkg::SCX_RS_EXT, 32'h00000080);
    step(.aux(3'h4));
    chk(36'({tlb_flush_all, tlb_flush_nonglobal}), 36'h1);
    wr(scx_pkg::SCX_RS_EXT, 32'h00000000);
    step(.aux(3'h4));
    chk(36'({tlb_flush_all, tlb_flush_nonglobal}), 36'h2);
    $display("test paging flags done");
    // descriptor loads
    step(.aux(3'h2), .da(8'h80));
    chk(36'(desc_invalid), 36'h1);
    step(.aux(3'h2), .da(8'h00));
    chk(36'(desc_invalid), 36'h1);
    step(.aux(3'h2), .da(8'h93));
    chk(36'({desc_invalid, desc_locked_rmw}), 36'h0);
    step(.aux(3'h2), .da(8'h92));
    chk(36'({desc_invalid, desc_locked_rmw}), 36'h1);
    $display("test descriptors done");
    // core conditions and their vectors
    wr(scx_pkg::SCX_RS_EXT, 32'h00000040);
    cv = '0;
    cv.hw_err = 1'b1;
    step(.c(cv));
    chk_trap(1'b1, scx_pkg::VEC_MCHECK);
    cv = '0;
    cv.vf_err = 1'b1;
    cv.vf_flags = 6'h05;
    step(.c(cv));
    chk_trap(1'b1, scx_pkg::VEC_VFLOAT);
    chk(36'(vf_status), 36'h05);
    cv = '0;
    cv.pte_rsvd = 1'b1;
    step(.c(cv));
    chk_trap(1'b1, scx_pkg::VEC_PAGE);
    cv = '0;
    cv.unaligned = 1'b1;
    step(.c(cv));
    chk_trap(1'b0, 8'h00);
    cv.align_on = 1'b1;
    step(.c(cv));
    chk_trap(1'b1, scx_pkg::VEC_ALIGN);
    cv = '0;
    cv.divide_err = 1'b1;
    step(.c(cv));
    chk_trap(1'b1, scx_pkg::VEC_DIVIDE);
    chk(36'(trap.fault_ptr), 36'h1);
    cv = '0;
    cv.lock_misuse = 1'b1;
    step(.c(cv));
    chk_trap(1'b1, scx_pkg::VEC_OPCODE);
    cv = '0;
    cv.insn_len = 5'h0F;
    step(.c(cv));
    chk_trap(1'b0, 8'h00);
    cv.insn_len = 5'h10;
    step(.c(cv));
    chk_trap(1'b1, scx_pkg::VEC_PROTECT);
    $display("test conditions done");
    // a second reset leaves the machine check inhibited again
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd(scx_pkg::SCX_RS_EXT);
    chk(36'(rd_data), 36'h000000000);
    cv = '0;
    cv.hw_err = 1'b1;
    step(.c(cv));
    chk_trap(1'b0, 8'h00);
    $display("test second reset done");
    conclude();
  end

endmodule : system_control_exception_checks_tb_top
